/* dil_buf.sv */
// small fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dil_buf #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("buffer depth must be a power of two, at least two");
   end
   if (WIDTH < 1) begin : g_bad_width
      $error("buffer width must be positive");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign in_ready = (cnt_r != CNT_FULL);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_nxt = push ? wr_r + PTR_ONE : wr_r;
      rd_nxt = pop ? rd_r + PTR_ONE : rd_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else if (clk_en) begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage needs no reset; it is never read while empty
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge ref_clk) begin
         if (clk_en && push && wr_r == PTR_W'(i)) begin
            mem_r[i] <= in_data;
         end
      end
   end
endmodule
`default_nettype wire

/* dil_pkg.sv */
// constants and carrier types for the converter input latch and format block
package dil_pkg;
   localparam int WORD_W = 12;
   localparam int MSB_POS = 11;
   localparam int LSB_POS = 0;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SLEEP_ENTER_NS = 5000;
   localparam int WAKE_MS = 3;
   localparam int WAKE_NS = WAKE_MS * 1000000;
   localparam int MAX_RATE_MSPS = 125;
   localparam int MIN_SAMPLE_NS = 1000 / MAX_RATE_MSPS;
   // longest time rounds down, never below one cycle
   localparam int ENTER_CYC_RAW = SLEEP_ENTER_NS / CLK_PERIOD_NS;
   localparam int ENTER_CYC = (ENTER_CYC_RAW < 1) ? 1 : ENTER_CYC_RAW;
   // least time rounds up
   localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYC_RAW = MIN_SAMPLE_NS / CLK_PERIOD_NS;
   localparam int MIN_GAP_CYC = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
   localparam int CNT_W = 16;
   localparam int GAP_W = 8;
   localparam int BUF_DEPTH = 2;
   localparam logic FMT_BINARY = 1'b0;
   localparam logic FMT_TWOS = 1'b1;
   localparam logic [WORD_W-1:0] CODE_ZERO = 12'h000;
   localparam logic [WORD_W-1:0] CODE_FULL = 12'hFFF;
   localparam logic [WORD_W-1:0] MSB_MASK = 12'h800;

   typedef enum {
      ST_AWAKE,
      ST_ENTER,
      ST_ASLEEP,
      ST_WAKE
   } dil_pwr_state_type;

   typedef struct packed {
      logic [WORD_W-1:0] primary;
      logic [WORD_W-1:0] complementary;
   } dil_sample_type;
endpackage

/* dil_src.sv */
// signal source model driving the converter's sample clock, data word and coding pin
`timescale 1ns/1ns
`default_nettype none
module dil_src (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [dil_pkg::WORD_W-1:0] word,
   input wire logic fmt,
   output logic sample_clk,
   output logic [dil_pkg::WORD_W-1:0] data_in,
   output logic format_sel
);
   logic go_s;

   initial begin
      sample_clk = 1'b0;
      data_in = 12'h000;
      format_sel = 1'b0;
   end

   always @(posedge ref_clk) begin
      go_s = go;
      #1;
      // one high sample per word keeps rising edges at least two cycles apart
      if (go_s && !sample_clk) begin
         sample_clk = 1'b1;
         data_in = word;
         format_sel = fmt;
      end else begin
         sample_clk = 1'b0;
         // hold time over: a changing pattern, so a late capture cannot pass by luck
         data_in = ~data_in;
      end
   end
endmodule
`default_nettype wire

/* dil_tb.sv */
// self-checking bench for the converter input latch and format block
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int ENTER_N = 4;
   localparam int WAKE_N = 20;
   logic ref_clk, arst_n, clk_en, power_down, core_ready, go, fmt;
   logic sample_clk, format_sel, out_valid, accept_ready, sleeping, output_ok;
   logic overrun, rate_err;
   logic [11:0] word, data_in, prim, comp;
   logic [11:0] q[$];
   int mismatches;
   int cmp_count;

   dil_src dil_src_inst (.ref_clk(ref_clk), .go(go), .word(word), .fmt(fmt),
      .sample_clk(sample_clk), .data_in(data_in), .format_sel(format_sel));

   dil_top #(.ENTER_CYC(ENTER_N), .WAKE_CYC(WAKE_N)) dil_top_inst (
      .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .sample_clk(sample_clk),
      .data_in(data_in), .format_sel(format_sel), .power_down(power_down),
      .core_ready(core_ready), .primary_current_out(prim),
      .complementary_current_out(comp), .out_valid(out_valid),
      .accept_ready(accept_ready), .sleeping(sleeping), .output_ok(output_ok),
      .overrun(overrun), .rate_err(rate_err));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic fail(input string what);
      mismatches++;
      $display("ERROR %0t timeout: %s", $time, what);
      tally_and_finish();
   endtask

   // returns at the edge where the core samples the raised sample clock
   task automatic send(input logic [11:0] w, input logic f);
      @(posedge ref_clk);
      #1;
      go = 1'b1;
      word = w;
      fmt = f;
      @(posedge ref_clk);
      #1;
      go = 1'b0;
      @(posedge ref_clk);
   endtask

   // needs core_ready high; the word is taken at the edge after the check
   task automatic get_word(input logic [11:0] exp);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (out_valid !== 1'b1) begin
         n++;
         if (n > 50) begin
            fail("no output word");
         end
         @(negedge ref_clk);
      end
      check(prim, exp, "primary");
      check(comp, ~exp, "complementary");
      @(posedge ref_clk);
   endtask

   task automatic reset_test();
      check(prim, 12'h000, "reset primary");
      check(comp, 12'hFFF, "reset complementary");
      check({11'h000, output_ok}, 12'h001, "reset output_ok");
      check({11'h000, sleeping}, 12'h000, "reset sleeping");
   endtask

   // single-bit and boundary codes expose bit order and polarity slips
   task automatic binary_test();
      logic [11:0] tbl[6];
      tbl = '{12'h000, 12'hFFF, 12'h800, 12'h001, 12'h7FF, 12'hA5C};
      foreach (tbl[i]) begin
         send(tbl[i], dil_pkg::FMT_BINARY);
         get_word(tbl[i]);
      end
   endtask

   task automatic twos_test();
      logic [11:0] tbl[5];
      tbl = '{12'h800, 12'h7FF, 12'h000, 12'hFFF, 12'h123};
      foreach (tbl[i]) begin
         send(tbl[i], dil_pkg::FMT_TWOS);
         get_word(tbl[i] ^ 12'h800);
      end
   endtask

   // stalled core: fill until refused, overflow, then drain in order
   task automatic stall_test();
      int n;
      // off the edge, so the last word of the previous scenario still drains
      #1;
      core_ready = 1'b0;
      q.delete();
      n = 0;
      while (accept_ready === 1'b1 && n < 10) begin
         send(12'h100 + 12'(n), dil_pkg::FMT_BINARY);
         q.push_back(12'h100 + 12'(n));
         n++;
         #1;
      end
      if (n >= 10) begin
         fail("buffer never full");
      end
      send(12'hE01, dil_pkg::FMT_BINARY);
      send(12'hE02, dil_pkg::FMT_BINARY);
      repeat (4) @(posedge ref_clk);
      #1;
      check({11'h000, overrun}, 12'h001, "overrun");
      check(prim, q[0], "held word");
      check({11'h000, out_valid}, 12'h001, "held valid");
      core_ready = 1'b1;
      get_word(q[0]);
      get_word(q[1]);
      get_word(q[2]);
      repeat (8) @(posedge ref_clk);
   endtask

   // clock enable low: a sample edge must leave out_valid and the primary output untouched
   task automatic freeze_test();
      @(posedge ref_clk);
      #1;
      clk_en = 1'b0;
      send(12'h0F0, dil_pkg::FMT_BINARY);
      repeat (4) @(posedge ref_clk);
      #1;
      check({11'h000, out_valid}, 12'h000, "frozen valid");
      check(prim, 12'h5A5, "frozen primary");
      clk_en = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      check({11'h000, out_valid}, 12'h000, "no late word");
   endtask

   task automatic sleep_test();
      @(posedge ref_clk);
      #1;
      power_down = 1'b1;
      @(posedge ref_clk);
      #1;
      check({11'h000, output_ok}, 12'h000, "output_ok on entry");
      repeat (ENTER_N - 1) @(posedge ref_clk);
      #1;
      check({11'h000, sleeping}, 12'h000, "sleep too early");
      @(posedge ref_clk);
      #1;
      check({11'h000, sleeping}, 12'h001, "sleeping");
      send(12'h3C3, dil_pkg::FMT_BINARY);
      repeat (6) @(posedge ref_clk);
      #1;
      check({11'h000, out_valid}, 12'h000, "word while asleep");
      power_down = 1'b0;
      @(posedge ref_clk);
      #1;
      check({11'h000, sleeping}, 12'h000, "sleep left");
      repeat (WAKE_N - 1) @(posedge ref_clk);
      #1;
      check({11'h000, output_ok}, 12'h000, "wake too early");
      @(posedge ref_clk);
      #1;
      check({11'h000, output_ok}, 12'h001, "awake");
      send(12'h5A5, dil_pkg::FMT_BINARY);
      get_word(12'h5A5);
   endtask

   initial begin
      mismatches = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      power_down = 1'b0;
      core_ready = 1'b1;
      go = 1'b0;
      fmt = 1'b0;
      word = 12'h000;
      repeat (16) @(posedge ref_clk);
      reset_test();
      #1;
      arst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      binary_test();
      twos_test();
      stall_test();
      sleep_test();
      freeze_test();
      check({11'h000, rate_err}, 12'h000, "rate flag");
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* dil_top.sv */
// input latch, coding select and sleep control of the 12-bit converter front end
// What this block does
// - each rising sample clock edge seen while clock enable is high captures the whole input word; it holds between edges
// - input word is 12 bits, bit 11 most significant, bit 0 least
// - straight binary or twos complement chosen by format select, same amplitude scale
// - format select defaults to setting 0 when left open or grounded
// - primary output reaches full scale when every latched bit is one in straight binary, or at 7FF in twos complement
// - complementary output reaches full scale when every latched bit is zero in straight binary, or at 800 in twos complement
// - power-down acts independent of the sample clock; high puts converter to sleep
// - power-down defaults low, so the converter runs normally when left open
// - sleep entry takes about 5 us; wake needs 3 ms before valid output
// - sample updates up to 125 MSPS; edges MIN_GAP_CYC or fewer system clocks apart are flagged, a gap that no two detected edges can have
`timescale 1ns/1ns
`default_nettype none
module dil_top #(
   parameter int WORD_W = dil_pkg::WORD_W,
   parameter int BUF_DEPTH = dil_pkg::BUF_DEPTH,
   parameter int ENTER_CYC = dil_pkg::ENTER_CYC,
   parameter int WAKE_CYC = dil_pkg::WAKE_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic sample_clk,
   input wire logic [WORD_W-1:0] data_in,
   input wire logic format_sel,
   input wire logic power_down,
   input wire logic core_ready,
   output logic [WORD_W-1:0] primary_current_out,
   output logic [WORD_W-1:0] complementary_current_out,
   output logic out_valid,
   output logic accept_ready,
   output logic sleeping,
   output logic output_ok,
   output logic overrun,
   output logic rate_err
);
   localparam int CNT_W = dil_pkg::CNT_W;
   localparam int GAP_W = dil_pkg::GAP_W;
   localparam int SW = $bits(dil_pkg::dil_sample_type);
   localparam logic [CNT_W-1:0] ENTER_LOAD = CNT_W'(ENTER_CYC - 1);
   localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYC - 1);
   localparam logic [GAP_W-1:0] GAP_MIN = GAP_W'(dil_pkg::MIN_GAP_CYC);
   localparam logic [GAP_W-1:0] GAP_TOP = '1;
   localparam int ENTER_MAX = dil_pkg::ENTER_CYC + 2;

   // the word width is fixed by the pin count and the core
   if (WORD_W != dil_pkg::WORD_W) begin : g_bad_word
      $error("word width must match the converter core");
   end
   if (ENTER_CYC < 1 || WAKE_CYC < 1 || WAKE_CYC >= (1 << CNT_W)
       || ENTER_CYC >= (1 << CNT_W)) begin : g_bad_cnt
      $error("sleep timing counts out of range");
   end

   // ---------------- sample capture ----------------
   logic sclk_prev_r, sclk_prev_nxt;
   logic [WORD_W-1:0] latch_r, latch_nxt;
   logic fmt_r, fmt_nxt;
   logic [GAP_W-1:0] gap_r, gap_nxt;
   logic rate_err_r, rate_err_nxt;
   logic overrun_r, overrun_nxt;
   logic push_r, push_nxt;
   logic accept_ready_r, accept_ready_nxt;
   logic rise;
   logic awake;
   logic buf_in_ready;

   assign rise = sample_clk && !sclk_prev_r;

   always_comb begin
      sclk_prev_nxt = sample_clk;
      latch_nxt = latch_r;
      fmt_nxt = fmt_r;
      push_nxt = 1'b0;
      overrun_nxt = overrun_r;
      rate_err_nxt = rate_err_r;
      gap_nxt = (gap_r == GAP_TOP) ? gap_r : gap_r + 1'b1;
      if (rise) begin
         // whole word and its coding taken together on the edge
         latch_nxt = data_in;
         // an open select pin reads low, which is straight binary
         fmt_nxt = (format_sel == dil_pkg::FMT_TWOS);
         gap_nxt = '0;
         // edges MIN_GAP_CYC or fewer system clocks apart are flagged, word still kept
         if (gap_r < GAP_MIN) begin
            rate_err_nxt = 1'b1;
         end
         // words arriving while asleep are latched but not converted
         push_nxt = awake;
         if (awake && !buf_in_ready) begin
            overrun_nxt = 1'b1;
         end
      end
      accept_ready_nxt = buf_in_ready;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_prev_r <= 1'b0;
         latch_r <= dil_pkg::CODE_ZERO;
         fmt_r <= dil_pkg::FMT_BINARY;
         gap_r <= '1;
         rate_err_r <= 1'b0;
         overrun_r <= 1'b0;
         push_r <= 1'b0;
         accept_ready_r <= 1'b0;
      end else if (clk_en) begin
         sclk_prev_r <= sclk_prev_nxt;
         latch_r <= latch_nxt;
         fmt_r <= fmt_nxt;
         gap_r <= gap_nxt;
         rate_err_r <= rate_err_nxt;
         overrun_r <= overrun_nxt;
         push_r <= push_nxt;
         accept_ready_r <= accept_ready_nxt;
      end
   end

   // ---------------- coding to offset binary ----------------
   dil_pkg::dil_sample_type push_data;
   logic [WORD_W-1:0] core_code;

   always_comb begin
      core_code = latch_r;
      if (fmt_r) begin
         core_code = latch_r ^ dil_pkg::MSB_MASK;
      end
      push_data.primary = core_code;
      push_data.complementary = ~core_code;
   end

   // ---------------- buffer toward the converter core ----------------
   logic buf_out_valid;
   logic buf_out_ready;
   logic [SW-1:0] buf_out_data;
   logic buf_push_ok;
   dil_pkg::dil_sample_type head;

   assign buf_push_ok = push_r && buf_in_ready;
   assign head = buf_out_data;
   assign buf_out_ready = !out_valid || core_ready;

   dil_buf #(
      .WIDTH(SW),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .in_valid(buf_push_ok),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   logic [WORD_W-1:0] prim_r, prim_nxt, comp_r, comp_nxt;
   logic out_valid_r, out_valid_nxt;

   always_comb begin
      prim_nxt = prim_r;
      comp_nxt = comp_r;
      out_valid_nxt = out_valid_r;
      if (buf_out_ready) begin
         out_valid_nxt = buf_out_valid;
         if (buf_out_valid) begin
            prim_nxt = head.primary;
            comp_nxt = head.complementary;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prim_r <= dil_pkg::CODE_ZERO;
         comp_r <= dil_pkg::CODE_FULL;
         out_valid_r <= 1'b0;
      end else if (clk_en) begin
         prim_r <= prim_nxt;
         comp_r <= comp_nxt;
         out_valid_r <= out_valid_nxt;
      end
   end

   // ---------------- sleep control ----------------
   dil_pkg::dil_pwr_state_type st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic sleeping_r, sleeping_nxt;
   logic ok_r, ok_nxt;

   // sampled on the system clock, never on the sample clock, so it works
   // while the source has stopped clocking words
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
      case (st_r)
         dil_pkg::ST_AWAKE: begin
            if (power_down) begin
               st_nxt = dil_pkg::ST_ENTER;
               cnt_nxt = ENTER_LOAD;
            end
         end
         dil_pkg::ST_ENTER: begin
            if (!power_down) begin
               // analog may already be half down: take the full wake time
               st_nxt = dil_pkg::ST_WAKE;
               cnt_nxt = WAKE_LOAD;
            end else if (cnt_r == '0) begin
               st_nxt = dil_pkg::ST_ASLEEP;
            end
         end
         dil_pkg::ST_ASLEEP: begin
            if (!power_down) begin
               st_nxt = dil_pkg::ST_WAKE;
               cnt_nxt = WAKE_LOAD;
            end
         end
         dil_pkg::ST_WAKE: begin
            if (power_down) begin
               st_nxt = dil_pkg::ST_ENTER;
               cnt_nxt = ENTER_LOAD;
            end else if (cnt_r == '0) begin
               st_nxt = dil_pkg::ST_AWAKE;
            end
         end
         default: begin
            st_nxt = dil_pkg::ST_WAKE;
            cnt_nxt = WAKE_LOAD;
         end
      endcase
      sleeping_nxt = (st_nxt == dil_pkg::ST_ASLEEP);
      ok_nxt = (st_nxt == dil_pkg::ST_AWAKE);
   end

   assign awake = (st_r == dil_pkg::ST_AWAKE);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= dil_pkg::ST_AWAKE;
         cnt_r <= '0;
         sleeping_r <= 1'b0;
         ok_r <= 1'b1;
      end else if (clk_en) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sleeping_r <= sleeping_nxt;
         ok_r <= ok_nxt;
      end
   end

   assign primary_current_out = prim_r;
   assign complementary_current_out = comp_r;
   assign out_valid = out_valid_r;
   assign accept_ready = accept_ready_r;
   assign sleeping = sleeping_r;
   assign output_ok = ok_r;
   assign overrun = overrun_r;
   assign rate_err = rate_err_r;

   // ---------------- checks ----------------
   property p_capture;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && sample_clk && !sclk_prev_r) |=> (latch_r == $past(data_in));
   endproperty
   a_capture: assert property (p_capture) else $error("word not captured on edge");

   property p_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      !(sample_clk && !sclk_prev_r) |=> $stable(latch_r);
   endproperty
   a_hold: assert property (p_hold) else $error("latched word changed between edges");

   property p_format;
      @(posedge ref_clk) disable iff (!arst_n)
      push_r |-> (push_data.primary[dil_pkg::MSB_POS] == (latch_r[dil_pkg::MSB_POS] ^ fmt_r))
         && (push_data.primary[dil_pkg::MSB_POS-1:dil_pkg::LSB_POS]
            == latch_r[dil_pkg::MSB_POS-1:dil_pkg::LSB_POS]);
   endproperty
   a_format: assert property (p_format) else $error("coding conversion wrong");

   property p_full_scale;
      @(posedge ref_clk) disable iff (!arst_n)
      (out_valid_r && prim_r == dil_pkg::CODE_FULL) |-> (comp_r == dil_pkg::CODE_ZERO);
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full scale pair wrong");

   property p_complement;
      @(posedge ref_clk) disable iff (!arst_n)
      out_valid_r |-> (comp_r == ~prim_r);
   endproperty
   a_complement: assert property (p_complement) else $error("outputs not complementary");

   property p_sleep_start;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && power_down && st_r == dil_pkg::ST_AWAKE) |=> (st_r == dil_pkg::ST_ENTER)
         && !output_ok;
   endproperty
   a_sleep_start: assert property (p_sleep_start) else $error("power-down ignored");

   property p_enter_time;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && $rose(st_r == dil_pkg::ST_ENTER) && power_down)
         ##1 (clk_en && power_down)[*8] |-> ##[0:ENTER_MAX] sleeping || !power_down || !clk_en;
   endproperty
   a_enter_time: assert property (p_enter_time) else $error("sleep entry too slow");

   property p_wake_time;
      @(posedge ref_clk) disable iff (!arst_n)
      $rose(output_ok) |-> ($past(st_r) == dil_pkg::ST_WAKE) && ($past(cnt_r) == '0);
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("woke before wake time");

   property p_rate;
      @(posedge ref_clk) disable iff (!arst_n)
      (clk_en && sample_clk && !sclk_prev_r && gap_r < GAP_MIN) |=> rate_err_r;
   endproperty
   a_rate: assert property (p_rate) else $error("fast sample edge not flagged");
endmodule
`default_nettype wire
